// >>> rtl/pbws_sequencer.sv
// top: system power state sequencer driven by power switch and wake sources
`timescale 1ns/10ps

// Functional notes
// - From soft-off, a short switch press powers the system on to working.
// - From working, a press past six seconds forces soft-off regardless of the OS.
// - From sleep, a short press wakes to working and a long press goes to soft-off.
// - From working, a short press only raises a sleep request; the OS picks the target.
// - Switch, RTC alarm, LAN, USB and PCIe wake are the only wake sources in S3/S4/S5.
// - USB wake from S4/S5 needs its enable, never from deep S4/S5 or after mech-off.
// - On return of AC the last on/off state is restored when that option is set.
// - In S3 only standby supply is on and the LED shows secondary colour or dark.
// - A valid wake from S3 returns quickly to the working state.
// - USB activity wakes from S3 unless the system has passed through mech-off.
module pbws_sequencer
	import pbws_pkg::*;
#(
	parameter logic [31:0] DEB_CYC  = pbws_pkg::DEB_CYC_DEF,
	parameter logic [31:0] LONG_CYC = pbws_pkg::LONG_CYC_DEF
) (
	input  wire logic  sys_clk,
	input  wire logic  reset,
	input  wire logic  ac_ok,
	input  wire logic  pwr_sw_n,
	input  wire logic  rtc_alarm,
	input  wire logic  lan_wake,
	input  wire logic  usb_activity,
	input  wire logic  pcie_wake_n,
	input  wire logic  other_wake,
	input  wire logic  os_sleep_s3,
	input  wire logic  os_sleep_s4,
	input  wire logic  os_soft_off,
	input  wire logic  restore_last,
	input  wire logic  usb_s45_wake_en,
	input  wire logic  deep_s45,
	input  wire logic  led_dual,
	output logic       cpu_pwr_en,
	output logic       main_pwr_en,
	output logic       stby_pwr_en,
	output logic       sleep_req,
	output logic       cold_boot,
	output logic [1:0] led_color,
	output logic [2:0] pwr_state
);
	import pbws_pkg::*;

	// two-stage synchronisers for every pin input
	// config pins ride the same chain, so a setting change takes two cycles to act
	logic [13:0] sync1;
	logic [13:0] sync2;
	logic [13:0] raw_in;
	assign raw_in = {os_soft_off, os_sleep_s4, os_sleep_s3, restore_last, usb_s45_wake_en,
		deep_s45, led_dual, ac_ok, ~pwr_sw_n, rtc_alarm, lan_wake, usb_activity,
		~pcie_wake_n, other_wake};

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sync1 <= 14'h0000;
			sync2 <= 14'h0000;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	logic s_soft_off, s_s4, s_s3, s_restore, s_usb_en, s_deep, s_dual, s_ac;
	logic s_sw, s_rtc, s_lan, s_usb, s_pcie, s_other;
	assign s_soft_off = sync2[13];
	assign s_s4       = sync2[12];
	assign s_s3       = sync2[11];
	assign s_restore  = sync2[10];
	assign s_usb_en   = sync2[9];
	assign s_deep     = sync2[8];
	assign s_dual     = sync2[7];
	assign s_ac       = sync2[6];
	assign s_sw       = sync2[5];
	assign s_rtc      = sync2[4];
	assign s_lan      = sync2[3];
	assign s_usb      = sync2[2];
	assign s_pcie     = sync2[1];
	assign s_other    = sync2[0];

	// press timing lives in its own module
	logic short_rel;
	logic long_hit;
	pbws_press_timer #(
		.DEB_CYC  (DEB_CYC),
		.LONG_CYC (LONG_CYC)
	) u_timer (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.sw_sync   (s_sw),
		.short_rel (short_rel),
		.long_hit  (long_hit)
	);

	// sequencer state
	pbws_state_e state;
	pbws_state_e next_state;
	logic        last_on;
	logic        next_last_on;
	logic        mech_off_seen;
	logic        next_mech_off_seen;
	logic        next_sleep_req;
	logic        next_cold_boot;
	logic        wake_any;
	logic        usb_ok;

	// usb wake qualification; mech-off history blocks it everywhere
	always_comb begin
		usb_ok = 1'b0;
		if (s_usb && !mech_off_seen) begin
			if (state == PBWS_S3)
				usb_ok = 1'b1;
			else if (s_usb_en && !s_deep)
				usb_ok = 1'b1;
		end
	end

	// other_wake is deliberately left out: it is not a wake source
	assign wake_any = short_rel || s_rtc || s_lan || s_pcie || usb_ok;

	// next state, last-on memory and request strobes
	always_comb begin
		next_state         = state;
		next_last_on       = last_on;
		next_mech_off_seen = mech_off_seen;
		next_sleep_req     = 1'b0;
		next_cold_boot     = 1'b0;
		case (state)
			PBWS_G3: begin
				next_mech_off_seen = 1'b1;
				if (s_ac) begin
					if (s_restore && last_on) begin
						next_state     = PBWS_S0;
						next_cold_boot = 1'b1;
					end else begin
						next_state = PBWS_S5;
					end
				end
			end
			PBWS_S0: begin
				next_last_on       = 1'b1;
				next_mech_off_seen = 1'b0;
				if (long_hit) begin
					next_state = PBWS_S5;
				end else if (s_soft_off) begin
					next_state = PBWS_S5;
				end else if (s_s4) begin
					next_state = PBWS_S4;
				end else if (s_s3) begin
					next_state = PBWS_S3;
				end else if (short_rel) begin
					next_sleep_req = 1'b1;
				end
			end
			PBWS_S3, PBWS_S4: begin
				if (long_hit) begin
					next_state   = PBWS_S5;
					next_last_on = 1'b0;
				end else if (wake_any) begin
					next_state = PBWS_S0;
					next_cold_boot = (state == PBWS_S4);
				end
			end
			PBWS_S5: begin
				next_last_on = 1'b0;
				if (wake_any) begin
					next_state     = PBWS_S0;
					next_cold_boot = 1'b1;
				end
			end
			default: next_state = PBWS_G3;
		endcase
		// losing ac overrides everything; strobes die with it so none is seen in G3
		if (!s_ac) begin
			next_state     = PBWS_G3;
			next_sleep_req = 1'b0;
			next_cold_boot = 1'b0;
		end
	end

	// rail and led outputs computed from the next state so they register together
	logic       next_cpu_pwr;
	logic       next_main_pwr;
	logic [1:0] next_led;
	always_comb begin
		next_cpu_pwr  = (next_state == PBWS_S0);
		next_main_pwr = (next_state == PBWS_S0);
		next_led      = LED_OFF;
		if (next_state == PBWS_S0)
			next_led = LED_PRIMARY;
		else if (next_state == PBWS_S3 && s_dual)
			next_led = LED_SECONDARY;
	end

	// registers: last_on is kept across mech-off by standby/battery domain reset
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state         <= PBWS_G3;
			last_on       <= LAST_ON_RST;
			mech_off_seen <= 1'b1;
			sleep_req     <= 1'b0;
			cold_boot     <= 1'b0;
			cpu_pwr_en    <= 1'b0;
			main_pwr_en   <= 1'b0;
			stby_pwr_en   <= 1'b0;
			led_color     <= LED_OFF;
			pwr_state     <= 3'h0;
		end else begin
			state         <= next_state;
			last_on       <= next_last_on;
			mech_off_seen <= next_mech_off_seen;
			sleep_req     <= next_sleep_req;
			cold_boot     <= next_cold_boot;
			cpu_pwr_en    <= next_cpu_pwr;
			main_pwr_en   <= next_main_pwr;
			stby_pwr_en   <= (next_state != PBWS_G3);
			led_color     <= next_led;
			pwr_state     <= 3'(next_state);
		end
	end

	// checks
	AST_LONG_OFF: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S0 && long_hit && s_ac) |=> (state == PBWS_S5 && !cpu_pwr_en))
		else $error("long press did not force soft-off");
	AST_ON_S5: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S5 && short_rel && s_ac) |=> (state == PBWS_S0 && cold_boot))
		else $error("short press from soft-off did not power on");
	AST_SLEEP_LONG: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S3 && long_hit && s_ac) |=> state == PBWS_S5)
		else $error("long press in sleep did not reach soft-off");
	AST_REQ_ONLY: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S0 && short_rel && s_ac && !s_s3 && !s_s4 && !s_soft_off)
		|=> (sleep_req && state == PBWS_S0))
		else $error("short press in working changed state");
	AST_CPU_OFF: assert property (@(posedge sys_clk) disable iff (reset)
		(state != PBWS_S0) |-> (!cpu_pwr_en && !main_pwr_en))
		else $error("processor powered outside working");
	AST_NO_OTHER: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S5 && !wake_any) |=> state != PBWS_S0)
		else $error("woke without a valid source");
	AST_USB_MECH: assert property (@(posedge sys_clk) disable iff (reset)
		(mech_off_seen && s_usb && state != PBWS_S0 && state != PBWS_G3 && !short_rel
		&& !s_rtc && !s_lan && !s_pcie) |=> state != PBWS_S0)
		else $error("usb woke after mech-off");
	AST_USB_DEEP: assert property (@(posedge sys_clk) disable iff (reset)
		((state == PBWS_S4 || state == PBWS_S5) && s_deep) |-> !usb_ok)
		else $error("usb wake allowed from deep state");
	AST_RESTORE: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_G3 && s_ac && s_restore && last_on) |=> state == PBWS_S0)
		else $error("last state not restored");
	AST_S3_LED: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S3) |-> (!main_pwr_en && stby_pwr_en && led_color != LED_PRIMARY))
		else $error("wrong rails or led in suspend");
	AST_S3_WAKE: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S3 && s_rtc && !long_hit && s_ac) |=> ##[0:1] cpu_pwr_en)
		else $error("suspend wake too slow");

	// wake paths and press decoding in the sleeping states
	AST_S4_LONG: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S4 && long_hit && s_ac) |=> state == PBWS_S5)
		else $error("long press in hibernate did not reach soft-off");
	AST_S3_SHORT: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S3 && short_rel && s_ac) |=> state == PBWS_S0)
		else $error("short press in suspend did not wake");
	AST_OTHER_IGN: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S3 && s_other && s_ac && !wake_any && !long_hit) |=> state == PBWS_S3)
		else $error("non-wake source left suspend");
	AST_USB_GATE: assert property (@(posedge sys_clk) disable iff (reset)
		((state == PBWS_S4 || state == PBWS_S5) && !s_usb_en) |-> !usb_ok)
		else $error("usb wake allowed while disabled");
	AST_PRESS_EXCL: assert property (@(posedge sys_clk) disable iff (reset)
		long_hit |-> !short_rel)
		else $error("press reported both long and short");

	// cold boot only where context was lost, and strobes only in working
	AST_COLD_S5: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S5 && wake_any && s_ac) |=> (state == PBWS_S0 && cold_boot))
		else $error("wake from soft-off without cold boot");
	AST_S3_WARM: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S3 && wake_any && !long_hit && s_ac) |=> (state == PBWS_S0 && !cold_boot))
		else $error("suspend wake was not a warm return");
	AST_CB_S0: assert property (@(posedge sys_clk) disable iff (reset)
		cold_boot |-> state == PBWS_S0)
		else $error("cold boot outside working");
	AST_SREQ_S0: assert property (@(posedge sys_clk) disable iff (reset)
		sleep_req |-> state == PBWS_S0)
		else $error("sleep request outside working");
	AST_NO_RESTORE: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_G3 && s_ac && !(s_restore && last_on)) |=> state == PBWS_S5)
		else $error("ac return did not stay off");

	// rails follow the state: full in working, standby everywhere but G3
	AST_G3_DARK: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_G3) |-> (!stby_pwr_en && !main_pwr_en && !cpu_pwr_en))
		else $error("rail on without ac");
	AST_STBY_ON: assert property (@(posedge sys_clk) disable iff (reset)
		(state != PBWS_G3) |-> stby_pwr_en)
		else $error("standby rail off with ac present");
	AST_S0_RAILS: assert property (@(posedge sys_clk) disable iff (reset)
		(state == PBWS_S0) |-> (cpu_pwr_en && main_pwr_en && stby_pwr_en))
		else $error("working state without full rails");
endmodule // pbws_sequencer

// >>> rtl/pbws_pkg.sv
// package: constants and state types for the power button wake sequencer
package pbws_pkg;
	// clock rate
	localparam int unsigned SYS_CLK_HZ       = 200_000_000;
	// press thresholds in milliseconds, debounce time in microseconds
	localparam int unsigned SHORT_PRESS_MS   = 4000;
	localparam int unsigned LONG_PRESS_MS    = 6000;
	localparam int unsigned DEBOUNCE_US      = 10_000;
	// derived cycle counts (long press must exceed, so it fires when the hold count equals LONG_CYC)
	localparam longint unsigned SHORT_CYC_L  = longint'(SHORT_PRESS_MS) * SYS_CLK_HZ / 1000;
	localparam longint unsigned LONG_CYC_L   = longint'(LONG_PRESS_MS) * SYS_CLK_HZ / 1000;
	localparam longint unsigned DEB_CYC_L    = longint'(DEBOUNCE_US) * SYS_CLK_HZ / 1_000_000;
	localparam int unsigned CNT_W            = 32;
	localparam logic [31:0] LONG_CYC_DEF     = LONG_CYC_L[31:0];
	localparam logic [31:0] DEB_CYC_DEF      = DEB_CYC_L[31:0];
	// reset values
	localparam logic        LAST_ON_RST      = 1'b0;
	localparam logic [31:0] CNT_RST          = 32'h0000_0000;
	// power states
	typedef enum logic [2:0] {
		PBWS_G3,
		PBWS_S0,
		PBWS_S3,
		PBWS_S4,
		PBWS_S5
	} pbws_state_e;
	// led colour codes
	localparam logic [1:0] LED_OFF           = 2'h0;
	localparam logic [1:0] LED_PRIMARY       = 2'h1;
	localparam logic [1:0] LED_SECONDARY     = 2'h2;
endpackage

// >>> rtl/pbws_press_timer.sv
// press timer: debounces the switch, reports a short press at release and a long press once the hold count reaches LONG_CYC
`timescale 1ns/10ps
module pbws_press_timer
	import pbws_pkg::*;
#(
	parameter logic [31:0] DEB_CYC  = pbws_pkg::DEB_CYC_DEF,
	parameter logic [31:0] LONG_CYC = pbws_pkg::LONG_CYC_DEF
) (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic sw_sync,
	output logic      short_rel,
	output logic      long_hit
);
	logic              level;
	logic              next_level;
	logic [CNT_W-1:0]  deb_cnt;
	logic [CNT_W-1:0]  next_deb_cnt;
	logic [CNT_W-1:0]  hold_cnt;
	logic [CNT_W-1:0]  next_hold_cnt;
	logic              long_seen;
	logic              next_long_seen;

	// debounce then time the held press; 4..6 s still counts as short
	always_comb begin
		next_level     = level;
		next_deb_cnt   = deb_cnt;
		next_hold_cnt  = hold_cnt;
		next_long_seen = long_seen;
		short_rel      = 1'b0;
		long_hit       = 1'b0;
		if (sw_sync != level) begin
			next_deb_cnt = deb_cnt + 32'h1;
			if (deb_cnt >= DEB_CYC) begin
				next_level   = sw_sync;
				next_deb_cnt = CNT_RST;
			end
		end else begin
			next_deb_cnt = CNT_RST;
		end
		if (level) begin
			if (hold_cnt != 32'hFFFF_FFFF)
				next_hold_cnt = hold_cnt + 32'h1;
			if (hold_cnt == LONG_CYC && !long_seen) begin
				long_hit       = 1'b1;
				next_long_seen = 1'b1;
			end
			if (!next_level) begin
				short_rel      = !long_seen && !long_hit;
				next_hold_cnt  = CNT_RST;
				next_long_seen = 1'b0;
			end
		end
	end

	// state registers only
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			level     <= 1'b0;
			deb_cnt   <= CNT_RST;
			hold_cnt  <= CNT_RST;
			long_seen <= 1'b0;
		end else begin
			level     <= next_level;
			deb_cnt   <= next_deb_cnt;
			hold_cnt  <= next_hold_cnt;
			long_seen <= next_long_seen;
		end
	end
endmodule // pbws_press_timer

// >>> sim/pbws_wake_src.sv
// model of the power switch and the platform wake sources
`timescale 1ns/10ps
module pbws_wake_src (
	input  wire logic sys_clk,
	output logic      pwr_sw_n,
	output logic      rtc_alarm,
	output logic      lan_wake,
	output logic      usb_activity,
	output logic      pcie_wake_n,
	output logic      other_wake
);
	// 0 other, 1 usb, 2 rtc, 3 lan, 4 pcie, 5 switch
	logic [5:0] lines = 6'h00;
	// active-low pins idle high, as their pull-ups would hold them
	assign {rtc_alarm, usb_activity, other_wake} = lines[2:0];
	assign lan_wake    = lines[3];
	assign pcie_wake_n = ~lines[4];
	assign pwr_sw_n    = ~lines[5];
	// assert one source for n cycles, changing just after the edge
	task automatic hold(input int idx, input int n);
		@(posedge sys_clk);
		#1 lines[idx] = 1'b1;
		repeat (n) @(posedge sys_clk);
		#1 lines[idx] = 1'b0;
	endtask
endmodule // pbws_wake_src

// >>> sim/pbws_sequencer_tb.sv
// self-checking testbench for the power button wake sequencer
`timescale 1ns/10ps
module pbws_sequencer_tb;
	import pbws_pkg::*;
	logic sys_clk = 1'b0, reset = 1'b1, ac_ok = 1'b1, led_dual = 1'b1;
	logic os_sleep_s3 = 1'b0, os_sleep_s4 = 1'b0, os_soft_off = 1'b0;
	logic restore_last = 1'b0, usb_s45_wake_en = 1'b0, deep_s45 = 1'b0;
	logic pwr_sw_n, rtc_alarm, lan_wake, usb_activity, pcie_wake_n, other_wake;
	logic cpu_pwr_en, main_pwr_en, stby_pwr_en, sleep_req, cold_boot;
	logic [1:0] led_color;
	logic [2:0] pwr_state;
	int fail_count = 0, tests_run = 0, sreq_cnt = 0, cb_cnt = 0;
	wire [7:0] rails = {3'h0, cpu_pwr_en, main_pwr_en, stby_pwr_en, led_color};

	pbws_wake_src src (.sys_clk(sys_clk), .pwr_sw_n(pwr_sw_n), .rtc_alarm(rtc_alarm),
		.lan_wake(lan_wake), .usb_activity(usb_activity), .pcie_wake_n(pcie_wake_n),
		.other_wake(other_wake));
	// short counts keep the run brief: debounce 4, long press 50 cycles
	pbws_sequencer #(.DEB_CYC(32'h4), .LONG_CYC(32'h32)) DUT (.sys_clk(sys_clk),
		.reset(reset), .ac_ok(ac_ok), .pwr_sw_n(pwr_sw_n), .rtc_alarm(rtc_alarm),
		.lan_wake(lan_wake), .usb_activity(usb_activity), .pcie_wake_n(pcie_wake_n),
		.other_wake(other_wake), .os_sleep_s3(os_sleep_s3), .os_sleep_s4(os_sleep_s4),
		.os_soft_off(os_soft_off), .restore_last(restore_last),
		.usb_s45_wake_en(usb_s45_wake_en), .deep_s45(deep_s45), .led_dual(led_dual),
		.cpu_pwr_en(cpu_pwr_en), .main_pwr_en(main_pwr_en), .stby_pwr_en(stby_pwr_en),
		.sleep_req(sleep_req), .cold_boot(cold_boot), .led_color(led_color),
		.pwr_state(pwr_state));

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	// one-cycle pulses are counted so a later check cannot miss them
	always @(posedge sys_clk) begin
		if (sleep_req === 1'b1) sreq_cnt++;
		if (cold_boot === 1'b1) cb_cnt++;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// bounded wait for a state, then compare it
	task automatic wait_st(input logic [2:0] e);
		for (int i = 0; i < 200 && pwr_state !== e; i++) @(posedge sys_clk);
		#1 chk(pwr_state, e);
	endtask
	// os target order: {soft_off, s4, s3}, held long enough to be seen
	task automatic os_req(input logic [2:0] r);
		{os_soft_off, os_sleep_s4, os_sleep_s3} = r;
		settle(20);
		{os_soft_off, os_sleep_s4, os_sleep_s3} = 3'h0;
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// watchdog: the sequence needs a few thousand cycles at most
	initial begin
		#250000;
		fail_count++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 reset = 1'b0;
		wait_st(PBWS_S5);
		chk(rails, 8'h04);
		src.hold(5, 20);
		wait_st(PBWS_S0);
		chk(rails, 8'h1D);
		chk(8'(cb_cnt), 8'h01);
		src.hold(5, 20);
		settle(20);
		chk(8'(sreq_cnt), 8'h01);
		chk(pwr_state, PBWS_S0);
		os_req(3'h1);
		chk(pwr_state, PBWS_S3);
		chk(rails, 8'h06);
		src.hold(0, 10);
		settle(20);
		chk(pwr_state, PBWS_S3);
		src.hold(1, 10);
		wait_st(PBWS_S0);
		chk(8'(cb_cnt), 8'h01);
		src.hold(5, 80);
		wait_st(PBWS_S5);
		chk(8'(sreq_cnt), 8'h01);
		// usb wake from soft-off: disabled, deep, then allowed
		for (int k = 0; k < 3; k++) begin
			usb_s45_wake_en = (k != 0);
			deep_s45 = (k == 1);
			src.hold(1, 10);
			settle(20);
			chk(pwr_state, (k == 2) ? PBWS_S0 : PBWS_S5);
		end
		// rtc from S3, lan from S4, pcie from S5
		for (int k = 0; k < 3; k++) begin
			os_req(3'h1 << k);
			chk(pwr_state, 8'(k + 2));
			src.hold(k + 2, 10);
			wait_st(PBWS_S0);
		end
		// lan from S4 and pcie from S5 each start a cold boot, rtc from S3 does not
		chk(8'(cb_cnt), 8'h04);
		os_req(3'h1);
		src.hold(5, 45);
		wait_st(PBWS_S0);
		os_req(3'h1);
		src.hold(5, 80);
		wait_st(PBWS_S5);
		src.hold(5, 2);
		settle(20);
		chk(pwr_state, PBWS_S5);
		// power loss while on, then while off
		src.hold(5, 20);
		wait_st(PBWS_S0);
		restore_last = 1'b1;
		ac_ok = 1'b0;
		wait_st(PBWS_G3);
		chk(rails, 8'h00);
		ac_ok = 1'b1;
		wait_st(PBWS_S0);
		os_req(3'h4);
		ac_ok = 1'b0;
		wait_st(PBWS_G3);
		ac_ok = 1'b1;
		wait_st(PBWS_S5);
		src.hold(1, 10);
		settle(20);
		chk(pwr_state, PBWS_S5);
		// single-colour indicator stays dark in S3
		src.hold(5, 20);
		wait_st(PBWS_S0);
		led_dual = 1'b0;
		os_req(3'h1);
		chk(rails, 8'h04);
		chk(8'(cb_cnt), 8'h07);
		// restore option off: a system that was on comes back to soft-off
		restore_last = 1'b0;
		ac_ok = 1'b0;
		wait_st(PBWS_G3);
		ac_ok = 1'b1;
		wait_st(PBWS_S5);
		chk(8'(sreq_cnt), 8'h01);
		tally_and_finish();
	end
endmodule // pbws_sequencer_tb
